// file: verilog/wmd_map.vh
`ifndef WMD_MAP_VH
`define WMD_MAP_VH

// first-byte opcodes
`define WMD_OP_IMM_PR_HI 5'h0c
`define WMD_OP_PREFIX    8'h3c
`define WMD_OP_IMM_SA    8'h0c
`define WMD_OP_IMM_SFR   8'h0b
`define WMD_OP_IMM_ABS   8'h09
`define WMD_OP_PR_PR     8'h24
`define WMD_OP_LD_SA2    8'h1c
`define WMD_OP_ST_SA2    8'h1a
`define WMD_OP_PR_MEM    8'h38
`define WMD_OP_LD_SFR    8'h11
`define WMD_OP_ST_SFR    8'h13
`define WMD_OP_SA_SA     8'h2a
`define WMD_OP_PR_ABS    8'h3e
`define WMD_OP_MEM_IND   8'h07
`define WMD_OP_REG_IND   8'h16
`define WMD_OP_BASED     8'h06
`define WMD_OP_INDEXED   8'h0a
`define WMD_OP_BASE_IDX  8'h17

// second-byte patterns
`define WMD_B2_ABS16     8'h41
`define WMD_B2_ABS24     8'h51
`define WMD_B2_SUFFIX    4'h1
`define WMD_B2_PAIR_TAG  2'h1
`define WMD_B2_SASA_TOP  2'h2
`define WMD_B2_SASA_LOW  4'h0
`define WMD_B2_MIND_TAG  2'h1
`define WMD_B2_NO_MODE   2'h3
`define WMD_BASED_MAX    3'h4

// form codes reported on completion
`define WMD_F_NONE       5'h00
`define WMD_F_IMM_PR     5'h01
`define WMD_F_IMM_SA     5'h02
`define WMD_F_IMM_SFR    5'h03
`define WMD_F_IMM_A16    5'h04
`define WMD_F_IMM_A24    5'h05
`define WMD_F_PR_PR      5'h06
`define WMD_F_AC_SA2     5'h07
`define WMD_F_PR_MEM     5'h08
`define WMD_F_AC_SFR     5'h09
`define WMD_F_SA_SA      5'h0a
`define WMD_F_PR_ABS     5'h0b
`define WMD_F_MEM_IND    5'h0c
`define WMD_F_REG_IND    5'h0d
`define WMD_F_BASED      5'h0e
`define WMD_F_INDEXED    5'h0f
`define WMD_F_BASE_IDX   5'h10

// operand byte counts after the opcode bytes
`define WMD_N_ZERO       3'h0
`define WMD_N_ONE        3'h1
`define WMD_N_TWO        3'h2
`define WMD_N_THREE      3'h3
`define WMD_N_FOUR       3'h4
`define WMD_N_FIVE       3'h5
`define WMD_OPS_MAX      5

`endif

// file: verilog/wmd_operand_collector.v
`timescale 1ns/1ps
`default_nettype none
`include "wmd_map.vh"

module wmd_operand_collector #(
  parameter MAX_BYTES = `WMD_OPS_MAX,
  parameter CNT_W     = 3
) (
  // clock and reset
  input  wire                   clk,
  input  wire                   reset,
  input  wire                   clk_en,
  // control
  input  wire                   start,
  input  wire [CNT_W-1:0]       need,
  input  wire                   clear,
  // byte stream
  input  wire                   take,
  input  wire [7:0]             byte_in,
  // collected operands, first byte in the low lane
  output reg  [8*MAX_BYTES-1:0] data,
  output wire                   full
);

  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] need_r;
  reg             active_r;

  // full also covers zero-operand forms one cycle after start
  assign full = active_r & (cnt_r == need_r);

  //////////////////////////////////////////////////////////////////////
  // bytes land in arrival order; count stops at need
  always @(posedge clk)
  begin
    if (reset)
    begin
      cnt_r    <= {CNT_W{1'b0}};
      need_r   <= {CNT_W{1'b0}};
      active_r <= 1'b0;
      data     <= {8*MAX_BYTES{1'b0}};
    end
    else if (clk_en)
    begin
      if (start)
      begin
        cnt_r    <= {CNT_W{1'b0}};
        need_r   <= need;
        active_r <= 1'b1;
        data     <= {8*MAX_BYTES{1'b0}};
      end
      else if (clear)
        active_r <= 1'b0;
      else if (take && active_r && !full)
      begin
        data[cnt_r*8 +: 8] <= byte_in;
        cnt_r              <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// file: verilog/wmd_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "wmd_map.vh"

module wmd_decoder (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  input  wire        clk_en,
  // instruction byte stream
  input  wire        byte_valid,
  input  wire [7:0]  byte_in,
  output wire        byte_ready,
  // status
  output wire        busy,
  output reg         done,
  output reg         reject,
  // decoded form and register fields
  output reg  [4:0]  form,
  output reg         store,
  output reg         area_one,
  output reg         src_area_one,
  output reg         wide,
  output reg  [2:0]  pair_dst,
  output reg  [2:0]  pair_src,
  output reg  [2:0]  sel,
  // decoded operand fields
  output reg  [7:0]  offset,
  output reg  [7:0]  src_offset,
  output reg  [23:0] addr,
  output reg  [15:0] imm
);

  localparam ST_FIRST  = 3'b001;
  localparam ST_SECOND = 3'b010;
  localparam ST_OPER   = 3'b100;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg         pre_r;
  reg         pre_nxt;
  reg  [7:0]  b1_r;
  reg  [7:0]  b1_nxt;
  reg  [4:0]  form_nxt;
  reg         store_nxt;
  reg         ar1_nxt;
  reg         sar1_nxt;
  reg         wide_nxt;
  reg  [2:0]  dst_nxt;
  reg  [2:0]  src_nxt;
  reg  [2:0]  sel_nxt;
  reg  [2:0]  need_nxt;
  reg         start_nxt;
  reg         go_oper;
  reg         rej_nxt;
  wire        acc;
  wire        col_full;
  wire [39:0] col_data;
  wire [7:0]  op0;
  wire [7:0]  op1;
  wire [7:0]  op2;
  wire [7:0]  op3;
  wire [7:0]  op4;

  //////////////////////////////////////////////////////////////////////
  // helpers

  // second bytes of the indirect, based and indexed forms all end in 0001
  function suffix_ok;
    input [7:0] b;
    begin
      suffix_ok = (b[3:0] == `WMD_B2_SUFFIX);
    end
  endfunction

  // 24-bit address arrives highest byte first, then low, then high
  function [23:0] addr24;
    input [7:0] hw;
    input [7:0] lo;
    input [7:0] hi;
    begin
      addr24 = {hw, hi, lo};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // handshake: hold off the stream while the result is assembled
  assign acc        = clk_en & byte_valid & byte_ready;
  assign byte_ready = clk_en & ~(state_r[2] & col_full);
  assign busy       = ~state_r[0] | pre_r;

  assign op0 = col_data[7:0];
  assign op1 = col_data[15:8];
  assign op2 = col_data[23:16];
  assign op3 = col_data[31:24];
  assign op4 = col_data[39:32];

  wmd_operand_collector #(
    .MAX_BYTES (`WMD_OPS_MAX),
    .CNT_W     (3)
  ) u_collector (
    .clk     (clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .start   (start_nxt),
    .need    (need_nxt),
    .clear   (state_r[2] & col_full),
    .take    (acc & state_r[2]),
    .byte_in (byte_in),
    .data    (col_data),
    .full    (col_full)
  );

  //////////////////////////////////////////////////////////////////////
  // opcode decode; fields of the pair number pass through unmapped
  always @*
  begin
    state_nxt = state_r;
    pre_nxt   = pre_r;
    b1_nxt    = b1_r;
    form_nxt  = form;
    store_nxt = store;
    ar1_nxt   = area_one;
    sar1_nxt  = src_area_one;
    wide_nxt  = wide;
    dst_nxt   = pair_dst;
    src_nxt   = pair_src;
    sel_nxt   = sel;
    need_nxt  = `WMD_N_ZERO;
    go_oper   = 1'b0;
    rej_nxt   = 1'b0;
    case (state_r)
      ST_FIRST:
        if (acc)
        begin
          b1_nxt    = byte_in;
          pre_nxt   = 1'b0;
          form_nxt  = `WMD_F_NONE;
          store_nxt = 1'b0;
          ar1_nxt   = pre_r;
          sar1_nxt  = 1'b0;
          wide_nxt  = 1'b0;
          dst_nxt   = 3'h0;
          src_nxt   = 3'h0;
          sel_nxt   = 3'h0;
          if (pre_r)
          begin
            // only two forms accept the area-one prefix
            case (byte_in)
              `WMD_OP_IMM_SA:
              begin
                form_nxt = `WMD_F_IMM_SA;
                need_nxt = `WMD_N_THREE;
                go_oper  = 1'b1;
              end
              `WMD_OP_MEM_IND:
                state_nxt = ST_SECOND;
              default:
                rej_nxt = 1'b1;
            endcase
          end
          else if (byte_in[7:3] == `WMD_OP_IMM_PR_HI)
          begin
            form_nxt = `WMD_F_IMM_PR;
            dst_nxt  = byte_in[2:0];
            need_nxt = `WMD_N_TWO;
            go_oper  = 1'b1;
          end
          else
          begin
            case (byte_in)
              `WMD_OP_PREFIX:
                pre_nxt = 1'b1;
              `WMD_OP_IMM_SA:
              begin
                form_nxt = `WMD_F_IMM_SA;
                need_nxt = `WMD_N_THREE;
                go_oper  = 1'b1;
              end
              `WMD_OP_IMM_SFR:
              begin
                form_nxt = `WMD_F_IMM_SFR;
                need_nxt = `WMD_N_THREE;
                go_oper  = 1'b1;
              end
              `WMD_OP_LD_SA2, `WMD_OP_ST_SA2:
              begin
                form_nxt  = `WMD_F_AC_SA2;
                store_nxt = (byte_in == `WMD_OP_ST_SA2);
                need_nxt  = `WMD_N_ONE;
                go_oper   = 1'b1;
              end
              `WMD_OP_LD_SFR, `WMD_OP_ST_SFR:
              begin
                form_nxt  = `WMD_F_AC_SFR;
                store_nxt = (byte_in == `WMD_OP_ST_SFR);
                need_nxt  = `WMD_N_ONE;
                go_oper   = 1'b1;
              end
              `WMD_OP_IMM_ABS, `WMD_OP_PR_PR, `WMD_OP_PR_MEM,
              `WMD_OP_SA_SA, `WMD_OP_PR_ABS, `WMD_OP_MEM_IND,
              `WMD_OP_REG_IND, `WMD_OP_BASED, `WMD_OP_INDEXED,
              `WMD_OP_BASE_IDX:
                state_nxt = ST_SECOND;
              default:
                rej_nxt = 1'b1;
            endcase
          end
        end
      ST_SECOND:
        if (acc)
        begin
          store_nxt = byte_in[7];
          sel_nxt   = byte_in[6:4];
          case (b1_r)
            `WMD_OP_IMM_ABS:
              if (byte_in == `WMD_B2_ABS16)
              begin
                form_nxt = `WMD_F_IMM_A16;
                store_nxt = 1'b0;
                need_nxt = `WMD_N_FOUR;
                go_oper  = 1'b1;
              end
              else if (byte_in == `WMD_B2_ABS24)
              begin
                form_nxt = `WMD_F_IMM_A24;
                store_nxt = 1'b0;
                wide_nxt = 1'b1;
                need_nxt = `WMD_N_FIVE;
                go_oper  = 1'b1;
              end
            `WMD_OP_PR_PR:
              if (byte_in[4:3] == `WMD_B2_PAIR_TAG)
              begin
                form_nxt  = `WMD_F_PR_PR;
                store_nxt = 1'b0;
                dst_nxt   = byte_in[7:5];
                src_nxt   = byte_in[2:0];
                go_oper   = 1'b1;
              end
            `WMD_OP_PR_MEM:
              if (byte_in[4:3] == `WMD_B2_PAIR_TAG &&
                  byte_in[1:0] != `WMD_B2_NO_MODE)
              begin
                form_nxt  = `WMD_F_PR_MEM;
                dst_nxt   = byte_in[7:5];
                store_nxt = byte_in[2];
                sel_nxt   = {1'b0, byte_in[1:0]};
                ar1_nxt   = (byte_in[1:0] == 2'h1);
                need_nxt  = `WMD_N_ONE;
                go_oper   = 1'b1;
              end
            `WMD_OP_SA_SA:
              if (byte_in[7:6] == `WMD_B2_SASA_TOP &&
                  byte_in[3:0] == `WMD_B2_SASA_LOW)
              begin
                form_nxt  = `WMD_F_SA_SA;
                store_nxt = 1'b0;
                sar1_nxt  = byte_in[4];
                ar1_nxt   = byte_in[5];
                need_nxt  = `WMD_N_TWO;
                go_oper   = 1'b1;
              end
            `WMD_OP_PR_ABS:
              if (byte_in[4:3] == `WMD_B2_PAIR_TAG && !byte_in[2])
              begin
                form_nxt  = `WMD_F_PR_ABS;
                dst_nxt   = byte_in[7:5];
                store_nxt = byte_in[0];
                wide_nxt  = byte_in[1];
                need_nxt  = byte_in[1] ? `WMD_N_THREE : `WMD_N_TWO;
                go_oper   = 1'b1;
              end
            `WMD_OP_MEM_IND:
              if (suffix_ok(byte_in) &&
                  byte_in[6:5] == `WMD_B2_MIND_TAG)
              begin
                form_nxt = `WMD_F_MEM_IND;
                wide_nxt = byte_in[4];
                need_nxt = `WMD_N_ONE;
                go_oper  = 1'b1;
              end
            `WMD_OP_REG_IND:
              if (suffix_ok(byte_in))
              begin
                form_nxt = `WMD_F_REG_IND;
                go_oper  = 1'b1;
              end
            `WMD_OP_BASED:
              if (suffix_ok(byte_in) && byte_in[6:4] <= `WMD_BASED_MAX)
              begin
                form_nxt = `WMD_F_BASED;
                need_nxt = `WMD_N_ONE;
                go_oper  = 1'b1;
              end
            `WMD_OP_INDEXED:
              if (suffix_ok(byte_in) && !byte_in[6])
              begin
                form_nxt = `WMD_F_INDEXED;
                need_nxt = `WMD_N_THREE;
                go_oper  = 1'b1;
              end
            `WMD_OP_BASE_IDX:
              if (suffix_ok(byte_in))
              begin
                form_nxt = `WMD_F_BASE_IDX;
                go_oper  = 1'b1;
              end
            default:
              go_oper = 1'b0;
          endcase
          if (!go_oper)
          begin
            state_nxt = ST_FIRST;
            rej_nxt   = 1'b1;
          end
        end
      ST_OPER:
        if (col_full)
          state_nxt = ST_FIRST;
      default:
        state_nxt = ST_FIRST;
    endcase
    if (go_oper)
      state_nxt = ST_OPER;
    start_nxt = go_oper;
  end

  //////////////////////////////////////////////////////////////////////
  // state and field registers; fields settle before done is raised
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_r      <= ST_FIRST;
      pre_r        <= 1'b0;
      b1_r         <= 8'h00;
      form         <= `WMD_F_NONE;
      store        <= 1'b0;
      area_one     <= 1'b0;
      src_area_one <= 1'b0;
      wide         <= 1'b0;
      pair_dst     <= 3'h0;
      pair_src     <= 3'h0;
      sel          <= 3'h0;
      done         <= 1'b0;
      reject       <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r      <= state_nxt;
      pre_r        <= pre_nxt;
      b1_r         <= b1_nxt;
      form         <= form_nxt;
      store        <= store_nxt;
      area_one     <= ar1_nxt;
      src_area_one <= sar1_nxt;
      wide         <= wide_nxt;
      pair_dst     <= dst_nxt;
      pair_src     <= src_nxt;
      sel          <= sel_nxt;
      done         <= state_r[2] & col_full;
      reject       <= rej_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // operand assembly from arrival order; unused fields read zero
  always @(posedge clk)
  begin
    if (reset)
    begin
      offset     <= 8'h00;
      src_offset <= 8'h00;
      addr       <= 24'h000000;
      imm        <= 16'h0000;
    end
    else if (clk_en && state_r[2] && col_full)
    begin
      offset     <= 8'h00;
      src_offset <= 8'h00;
      addr       <= 24'h000000;
      imm        <= 16'h0000;
      case (form)
        `WMD_F_IMM_PR:
          imm <= {op1, op0};
        `WMD_F_IMM_SA, `WMD_F_IMM_SFR:
        begin
          offset <= op0;
          imm    <= {op2, op1};
        end
        `WMD_F_IMM_A16:
        begin
          addr <= addr24(8'h00, op0, op1);
          imm  <= {op3, op2};
        end
        `WMD_F_IMM_A24:
        begin
          addr <= addr24(op0, op1, op2);
          imm  <= {op4, op3};
        end
        `WMD_F_SA_SA:
        begin
          src_offset <= op0;
          offset     <= op1;
        end
        `WMD_F_PR_ABS:
          if (wide)
            addr <= addr24(op0, op1, op2);
          else
            addr <= addr24(8'h00, op0, op1);
        `WMD_F_INDEXED:
          addr <= {op2, op1, op0};
        `WMD_F_AC_SA2, `WMD_F_AC_SFR, `WMD_F_PR_MEM,
        `WMD_F_MEM_IND, `WMD_F_BASED:
          offset <= op0;
        default:
          offset <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: verification/wmd_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "wmd_map.vh"

module wmd_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       clk_en,
  // byte stream
  input wire logic       byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic       byte_ready,
  // status
  input wire logic       busy,
  input wire logic       done,
  input wire logic       reject,
  // decoded fields
  input wire logic [4:0] form,
  input wire logic       store,
  input wire logic [2:0] pair_dst,
  input wire logic [2:0] pair_src,
  input wire logic [2:0] sel
);
  wire       take;
  reg  [7:0] lead_r;
  reg  [7:0] b2_r;
  reg  [2:0] pos_r;

  assign take = clk_en & byte_valid & byte_ready;

  // byte count per instruction, keyed on first and second byte
  function automatic [2:0] len_of(input [7:0] l, input [7:0] b);
    casez (l)
      8'b01100???:             len_of = 3'h3;
      8'h0c, 8'h0b, 8'h2a:     len_of = 3'h4;
      8'h3c:                   len_of = (b == 8'h0c) ? 3'h5 : 3'h4;
      8'h09:                   len_of = b[4] ? 3'h7 : 3'h6;
      8'h3e:                   len_of = b[1] ? 3'h5 : 3'h4;
      8'h38, 8'h07, 8'h06:     len_of = 3'h3;
      8'h0a:                   len_of = 3'h5;
      default:                 len_of = 3'h2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // track lead byte, second byte and count; a first byte is one taken while idle
  always @(posedge clk)
  begin
    if (reset)
    begin
      lead_r <= 8'h00;
      b2_r   <= 8'h00;
      pos_r  <= 3'h0;
    end
    else if (take)
    begin
      lead_r <= busy ? lead_r : byte_in;
      pos_r  <= busy ? pos_r + 3'h1 : 3'h1;
      if (busy && pos_r == 3'h1)
        b2_r <= byte_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // completion only after the whole operand list
  len_match_a: assert property (done |-> pos_r == len_of(lead_r, b2_r))
    else $error("done after wrong byte count");
  done_pulse_a: assert property (done && clk_en |=> !done)
    else $error("done longer than one cycle");
  reject_idle_a: assert property (reject && clk_en && !take |=> !reject && !busy)
    else $error("reject not back to idle");
  gap_done_a: assert property (!byte_ready && clk_en |=> done)
    else $error("assembly gap without done");
  imm_pair_a: assert property (done && lead_r[7:3] == 5'h0c |-> form == `WMD_F_IMM_PR && pair_dst == lead_r[2:0])
    else $error("immediate pair decode wrong");
  pair_move_a: assert property (done && lead_r == 8'h24 |-> pair_dst == b2_r[7:5] && pair_src == b2_r[2:0])
    else $error("pair to pair fields wrong");
  dir_sel_a: assert property (
    done && (lead_r == 8'h16 || lead_r == 8'h17 || lead_r == 8'h06 || lead_r == 8'h0a)
    |-> store == b2_r[7] && sel == b2_r[6:4])
    else $error("direction or selector wrong");
  form_lag_a: assert property (take && !busy && byte_in == 8'h1c |=> form == `WMD_F_AC_SA2 && busy)
    else $error("one byte opcode form late");
  sa_bad_a: assert property (
    take && busy && pos_r == 3'h1 && lead_r == 8'h2a
    && (byte_in[7:6] != 2'b10 || byte_in[3:0] != 4'h0) |=> reject)
    else $error("bad short direct move accepted");

  cover property (done && lead_r == 8'h09 && b2_r == 8'h51);
  cover property (reject && lead_r == 8'h3c);
  cover property (!byte_ready && !clk_en);
endmodule

bind wmd_decoder wmd_checker u_chk (
  .clk(clk), .reset(reset), .clk_en(clk_en), .byte_valid(byte_valid), .byte_in(byte_in),
  .byte_ready(byte_ready), .busy(busy), .done(done), .reject(reject), .form(form), .store(store),
  .pair_dst(pair_dst), .pair_src(pair_src), .sel(sel)
);
`default_nettype wire

// file: verification/wmd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wmd_map.vh"

module wmd_decoder_tb;
  // design ports
  logic        clk, reset, clk_en, byte_valid;
  logic [7:0]  byte_in;
  wire         byte_ready, busy, done, reject, store, area_one, src_area_one, wide;
  wire  [4:0]  form;
  wire  [2:0]  pair_dst, pair_src, sel;
  wire  [7:0]  offset, src_offset;
  wire  [23:0] addr;
  wire  [15:0] imm;
  // bench state and expectations
  int          error_cnt, n_checks, seed, cyc, nb, i;
  logic [55:0] sq;
  logic [11:0] care;
  logic [4:0]  e_form;
  logic        e_st, e_a1, e_sa1, e_w, e_rej;
  logic [2:0]  e_pd, e_ps, e_sel;
  logic [7:0]  e_off, e_soff;
  logic [23:0] e_addr;
  logic [15:0] e_imm;

  wmd_decoder dut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .byte_valid(byte_valid), .byte_in(byte_in),
    .byte_ready(byte_ready), .busy(busy), .done(done), .reject(reject), .form(form), .store(store),
    .area_one(area_one), .src_area_one(src_area_one), .wide(wide), .pair_dst(pair_dst),
    .pair_src(pair_src), .sel(sel), .offset(offset), .src_offset(src_offset), .addr(addr), .imm(imm)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the longest expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      results();
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task results;
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // operand byte: all zeros or all ones for the first two sweeps, random after
  function automatic logic [7:0] rb(input int n);
    rb = (n < 36) ? (n[0] ? 8'hff : 8'h00) : 8'($random(seed));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // build one instruction; care order is imm addr soff off sel ps pd w sa1 a1 st form
  task build(input int k, input int n);
    logic [31:0] rw;
    logic [7:0]  a, b, c, d, e, b2;
    logic [15:0] rj [0:6];
    rw = $random(seed);
    a = rb(n); b = rb(n); c = rb(n); d = rb(n); e = rb(n);
    rj = '{16'h3c0b, 16'h2a81, 16'h380b, 16'h0a41, 16'h0651, 16'h2410, 16'h2418};
    {e_st, e_a1, e_sa1, e_w, e_rej} = 5'h00;
    e_imm = {c, b}; e_off = a; e_pd = rw[7:5]; e_sel = rw[6:4];
    case (k)
      0: begin sq = {5'h0c, rw[2:0], a, b}; nb = 3; e_form = `WMD_F_IMM_PR; e_pd = rw[2:0];
         e_imm = {b, a}; care = 12'b1000_0010_0011; end
      1, 2: begin sq = (k == 2) ? {8'h3c, 8'h0c, a, b, c} : {8'h0c, a, b, c}; nb = k + 3;
         e_a1 = (k == 2); e_form = `WMD_F_IMM_SA; care = 12'b1001_0000_0111; end
      3: begin sq = {8'h0b, a, b, c}; nb = 4; e_form = `WMD_F_IMM_SFR; care = 12'b1001_0000_0011; end
      4: begin sq = {8'h09, 8'h41, a, b, c, d}; nb = 6; e_addr = {8'h00, b, a}; e_imm = {d, c};
         e_form = `WMD_F_IMM_A16; care = 12'b1100_0001_0011; end
      5: begin sq = {8'h09, 8'h51, a, b, c, d, e}; nb = 7; e_addr = {a, c, b}; e_imm = {e, d}; e_w = 1;
         e_form = `WMD_F_IMM_A24; care = 12'b1100_0001_0011; end
      6: begin sq = {8'h24, rw[7:5], 2'b01, rw[2:0]}; nb = 2; e_ps = rw[2:0];
         e_form = `WMD_F_PR_PR; care = 12'b0000_0110_0001; end
      7, 9: begin e_st = rw[0]; sq = {(k == 7) ? (e_st ? 8'h1a : 8'h1c) : (e_st ? 8'h13 : 8'h11), a};
         nb = 2; e_form = (k == 7) ? `WMD_F_AC_SA2 : `WMD_F_AC_SFR; care = 12'b0001_0000_0011; end
      8: begin b2 = {rw[7:5], 2'b01, rw[8], 2'(rw[1:0] % 3)}; sq = {8'h38, b2, a}; nb = 3;
         e_st = b2[2]; e_sel = {1'b0, b2[1:0]}; e_form = `WMD_F_PR_MEM; care = 12'b0001_1010_0011; end
      10: begin sq = {8'h2a, 2'b10, rw[1:0], 4'h0, a, b}; nb = 4; e_soff = a; e_off = b;
         e_a1 = rw[1]; e_sa1 = rw[0]; e_form = `WMD_F_SA_SA; care = 12'b0011_0000_1101; end
      11: begin b2 = {rw[7:5], 3'b010, rw[1:0]}; e_w = rw[1]; e_st = rw[0]; nb = e_w ? 5 : 4;
         sq = e_w ? {8'h3e, b2, a, b, c} : {8'h3e, b2, a, b}; e_addr = e_w ? {a, c, b} : {8'h00, b, a};
         e_form = `WMD_F_PR_ABS; care = 12'b0100_0011_0011; end
      12: begin b2 = {rw[0], 2'b01, rw[1], 4'h1}; e_st = rw[0]; e_w = rw[1]; e_a1 = rw[2];
         sq = e_a1 ? {8'h3c, 8'h07, b2, a} : {8'h07, b2, a}; nb = e_a1 ? 4 : 3;
         e_form = `WMD_F_MEM_IND; care = 12'b0001_0001_0111; end
      13, 16: begin sq = {(k == 13) ? 8'h16 : 8'h17, rw[7:4], 4'h1}; nb = 2; e_st = rw[7];
         e_form = (k == 13) ? `WMD_F_REG_IND : `WMD_F_BASE_IDX; care = 12'b0000_1000_0011; end
      14: begin e_sel = 3'(rw[10:8] % 5); sq = {8'h06, rw[7], e_sel, 4'h1, a}; nb = 3; e_st = rw[7];
         e_form = `WMD_F_BASED; care = 12'b0001_1000_0011; end
      15: begin e_sel = {1'b0, rw[5:4]}; sq = {8'h0a, rw[7], e_sel, 4'h1, a, b, c}; nb = 5; e_st = rw[7];
         e_addr = {c, b, a}; e_form = `WMD_F_INDEXED; care = 12'b0100_1000_0011; end
      default: begin e_rej = 1; care = 12'h000; nb = (rw[2:0] == 3'h7) ? 1 : 2;
         sq = (nb == 1) ? 56'hff : {40'h0, rj[rw[2:0]]}; end
    endcase
  endtask

  // send the bytes with random enable gaps, then wait for the outcome
  task run;
    int j, t;
    for (j = 0; j < nb; j++)
    begin
      byte_valid <= 1'b1;
      byte_in    <= sq[8*(nb-1-j) +: 8];
      clk_en     <= (({$random(seed)} % 4) != 0);
      @(posedge clk);
      for (t = 0; t < 8 && byte_ready !== 1'b1; t++)
      begin
        clk_en <= 1'b1;
        @(posedge clk);
      end
    end
    byte_valid <= 1'b0;
    for (t = 0; t < 10; t++)
    begin
      @(posedge clk);
      if (done === 1'b1 || reject === 1'b1)
        break;
    end
    check("reject", reject, e_rej);
    check("done", done, !e_rej);
    if (care[0]) check("form", form, e_form);
    if (care[1]) check("store", store, e_st);
    if (care[2]) check("area_one", area_one, e_a1);
    if (care[3]) check("src_area_one", src_area_one, e_sa1);
    if (care[4]) check("wide", wide, e_w);
    if (care[5]) check("pair_dst", pair_dst, e_pd);
    if (care[6]) check("pair_src", pair_src, e_ps);
    if (care[7]) check("sel", sel, e_sel);
    if (care[8]) check("offset", offset, e_off);
    if (care[9]) check("src_offset", src_offset, e_soff);
    if (care[10]) check("addr", addr, e_addr);
    if (care[11]) check("imm", imm, e_imm);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 50; cyc = 0; error_cnt = 0; n_checks = 0;
    clk_en = 1'b1; reset = 1'b1; byte_valid = 1'b0; byte_in = 8'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 1500; i++)
    begin
      // reset in mid-instruction, recovery shown by the next one
      if (i == 700)
      begin
        clk_en <= 1'b1; byte_valid <= 1'b1; byte_in <= 8'h0c;
        @(posedge clk);
        reset <= 1'b1; byte_valid <= 1'b0;
        @(posedge clk);
        check("busy", busy, 1'b1);
        reset <= 1'b0;
        @(posedge clk);
        check("busy", busy, 1'b0);
      end
      build((i < 36) ? i % 18 : {$random(seed)} % 18, i);
      run();
    end
    results();
  end
endmodule
`default_nettype wire
